/* File: rtl/microstore_pkg.sv */
// Constants for the microstore command port
package microstore_pkg;
   // Register byte offsets
   localparam logic [4:0] OFS_EXT_CMD = 5'h00;
   localparam logic [4:0] OFS_OUT76 = 5'h04;
   localparam logic [4:0] OFS_DATA75 = 5'h08;
   localparam logic [4:0] OFS_STATUS = 5'h0C;
   localparam logic [4:0] OFS_XFER_CNT = 5'h10;
   localparam logic [4:0] OFS_MEM_ADDR = 5'h14;
   localparam logic [4:0] OFS_MS_ADDR = 5'h18;
   // External command codes (076 .. 676 octal)
   localparam logic [8:0] EXT_INIT = 9'h03E;
   localparam logic [8:0] EXT_RUN_FREE = 9'h07E;
   localparam logic [8:0] EXT_MICRO_STEP = 9'h0BE;
   localparam logic [8:0] EXT_IO_STEP = 9'h0FE;
   localparam logic [8:0] EXT_CTRL_MODE = 9'h13E;
   localparam logic [8:0] EXT_SETUP_MODE = 9'h17E;
   localparam logic [8:0] EXT_MEM_LOAD = 9'h1BE;
   // Output word fields
   localparam int OP_HI = 15;
   localparam int OP_LO = 13;
   localparam int PAGE_HI = 12;
   localparam int PAGE_LO = 9;
   localparam int WADDR_HI = 8;
   localparam int BRANCH_HI = 12;
   // Command opcodes
   localparam logic [2:0] CMD_BRANCH = 3'h0;
   localparam logic [2:0] CMD_DEC_EN = 3'h1;
   localparam logic [2:0] CMD_IO_EN = 3'h3;
   // Setup opcodes
   localparam logic [2:0] SU_CENTRAL = 3'h0;
   localparam logic [2:0] SU_IO_STORE = 3'h3;
   localparam logic [2:0] SU_MEM_ADDR = 3'h4;
   localparam logic [2:0] SU_XFER_CNT = 3'h5;
   localparam logic [2:0] SU_IN_CS_ADDR = 3'h4;
   localparam logic [2:0] SU_IN_PIR = 3'h5;
   localparam logic [2:0] SU_IN_IO_ADDR = 3'h7;
   // Store organisation
   localparam int MODULE_WORDS = 256;
   localparam int STORE_WORDS = 512;
   localparam int CENTRAL_BITS = 64;
   localparam logic [1:0] LAST_LANE = 2'h3;
   // Status bit positions
   localparam int ST_BUSY = 0;
   localparam int ST_CTRL = 1;
   localparam int ST_LOAD = 2;
   localparam int ST_RUN = 3;
   localparam int ST_IO_PEND = 4;
   // Fine clock control states
   typedef enum logic [2:0] {
      CLK_FREE = 3'b000,
      CLK_WAIT_FULL = 3'b001,
      CLK_WAIT_HALF = 3'b011,
      CLK_HALTED = 3'b010,
      CLK_WAIT_IO = 3'b110
   } clk_state_e;
endpackage : microstore_pkg

/* File: rtl/microstore_io_command_port.sv */
// Microstore I/O command port with Avalon-MM register access
//
// Summary of operation
// - 256-word modules, up to 512 words of 64 bits.
// - Initialize deselects RAMs, aborts load, frees fine clock.
// - Run free lets fine clock run until a step.
// - Micro step: stop after half clock following next full clock.
// - I/O step: stop at next I/O address change.
// - Control mode makes device 76 words commands.
// - Setup mode makes device 76 words setup words.
// - Load copies memory into selected store.
// - Load counts words down, ends at zero.
// - Busy when clock runs, modules match, load active.
// - Optional interrupts are omitted.
// - Device 76 word: command in control mode, else setup.
// - Opcode bits 15-13, page 12-9, address 8-0.
// - Page field selects the module.
// - Command 000 branches to bits 12-0.
// - Command 001 enables decoder store of module.
// - Command 011 I/O RAM enable waits for idle.
// - Setup 000-011 select store; 000-100 load microstore address.
// - Setup 100 memory address, 101 transfer counter.
// - Input 100 central address, 101 pseudo IR, 111 I/O address.
// - Each store word moved steps microstore address; central store steps it every fourth word.
// - Central transfers start on whole word, four parts.
`timescale 1ns/1ns
module microstore_io_command_port
   import microstore_pkg::*;
#(
   parameter int ADDR_W = 9,
   parameter int MEM_AW = 16
) (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic [4:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic FULL_CLK,
   input wire logic HALF_CLK,
   input wire logic IO_ADDR_CHG,
   input wire logic IO_IDLE,
   input wire logic [3:0] PROC_MODULE,
   input wire logic [12:0] CUR_CS_ADDR,
   input wire logic [15:0] PSEUDO_IR,
   input wire logic [15:0] IO_ADDR,
   output logic FINE_CLK_EN,
   output logic BRANCH_STB,
   output logic [12:0] BRANCH_ADDR,
   output logic DEC_EN,
   output logic [3:0] DEC_MOD,
   output logic IO_RAM_EN,
   output logic [3:0] IO_RAM_MOD,
   output logic MEM_REQ,
   output logic [MEM_AW-1:0] MEM_ADDR,
   input wire logic MEM_ACK,
   input wire logic [15:0] MEM_RDATA,
   output logic CS_WE,
   output logic CS_RE,
   output logic [1:0] CS_SEL,
   output logic [ADDR_W-1:0] CS_ADDR,
   output logic [1:0] CS_LANE,
   output logic [15:0] CS_WDATA,
   input wire logic [15:0] CS_RDATA,
   output logic BUSY_SENSE
);

   // ==========================================================
   // State
   // ==========================================================
   clk_state_e clk_state_reg;
   logic wait_reg, rd_pend_reg, ctrl_mode_reg, load_reg, io_pend_reg;
   logic dec_en_reg, io_en_reg, branch_stb_reg, cs_we_reg, busy_reg;
   logic fine_run_reg;
   logic [31:0] rdata_reg;
   logic [2:0] su_op_reg, word_op;
   logic [3:0] page_reg, io_pend_mod_reg, dec_mod_reg, io_mod_reg;
   logic [15:0] cnt_reg, cs_wdata_reg, word;
   logic [MEM_AW-1:0] mar_reg;
   logic [ADDR_W-1:0] ms_addr_reg;
   logic [1:0] lane_reg;
   logic [12:0] branch_addr_reg;

   logic be_ok, hit75, stall, wr_go, rd_go, store_op, store_rd;
   logic wr_ext, wr_76, wr_75, load_ack, advance, clk_run, busy_next;
   logic [8:0] ext_code;

   // ==========================================================
   // Bus decode
   // ==========================================================
   assign be_ok = AVS_BYTEENABLE[0] & AVS_BYTEENABLE[1];
   assign hit75 = AVS_ADDRESS == OFS_DATA75;
   // Device 75 access waits while a memory load owns the store port
   assign stall = hit75 & load_reg;
   assign wr_go = AVS_WRITE & wait_reg & ~rd_pend_reg & ~stall;
   assign rd_go = AVS_READ & wait_reg & ~rd_pend_reg & ~stall;
   assign store_op = ~su_op_reg[2];
   assign store_rd = rd_go & hit75 & store_op;
   assign wr_ext = wr_go & be_ok & (AVS_ADDRESS == OFS_EXT_CMD);
   assign wr_76 = wr_go & be_ok & (AVS_ADDRESS == OFS_OUT76);
   assign wr_75 = wr_go & be_ok & hit75;
   assign ext_code = AVS_WRITEDATA[8:0];
   assign word = AVS_WRITEDATA[15:0];
   assign word_op = word[OP_HI:OP_LO];
   assign load_ack = load_reg & MEM_ACK;
   assign advance = load_ack | store_rd | (wr_75 & store_op);
   assign clk_run = fine_run_reg;
   assign busy_next = clk_run & (page_reg == PROC_MODULE) & load_reg;

   // Wait request: low for exactly one cycle per answer
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         wait_reg <= 1'b1;
      end else if (!wait_reg) begin
         wait_reg <= 1'b1;
      end else if (wr_go || rd_pend_reg || (rd_go && !store_rd)) begin
         wait_reg <= 1'b0;
      end
   end

   // Store read takes one extra cycle for the store to answer
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         rd_pend_reg <= 1'b0;
      end else begin
         rd_pend_reg <= store_rd;
      end
   end

   // Read data mux
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         rdata_reg <= 32'h00000000;
      end else if (rd_pend_reg) begin
         rdata_reg <= {16'h0000, CS_RDATA};
      end else if (rd_go) begin
         rdata_reg <= 32'h00000000;
         case (AVS_ADDRESS)
            OFS_STATUS: begin
               rdata_reg[ST_BUSY] <= busy_reg;
               rdata_reg[ST_CTRL] <= ctrl_mode_reg;
               rdata_reg[ST_LOAD] <= load_reg;
               rdata_reg[ST_RUN] <= clk_run;
               rdata_reg[ST_IO_PEND] <= io_pend_reg;
               rdata_reg[OP_HI:OP_LO] <= su_op_reg;
               rdata_reg[PAGE_HI:PAGE_LO] <= page_reg;
            end
            OFS_XFER_CNT: begin
               rdata_reg[15:0] <= cnt_reg;
            end
            OFS_MEM_ADDR: begin
               rdata_reg[MEM_AW-1:0] <= mar_reg;
            end
            OFS_MS_ADDR: begin
               rdata_reg[ADDR_W-1:0] <= ms_addr_reg;
            end
            OFS_DATA75: begin
               case (su_op_reg)
                  SU_IN_CS_ADDR: rdata_reg[12:0] <= CUR_CS_ADDR;
                  SU_IN_PIR: rdata_reg[15:0] <= PSEUDO_IR;
                  SU_IN_IO_ADDR: rdata_reg[15:0] <= IO_ADDR;
                  default: rdata_reg[15:0] <= 16'h0000;
               endcase
            end
            default: rdata_reg <= 32'h00000000; // Unmapped reads zero
         endcase
      end
   end

   // ==========================================================
   // Fine clock control
   // ==========================================================
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         clk_state_reg <= CLK_FREE;
         fine_run_reg <= 1'b1;
      end else if (wr_ext && (ext_code == EXT_INIT
                   || ext_code == EXT_RUN_FREE)) begin
         clk_state_reg <= CLK_FREE;
         fine_run_reg <= 1'b1;
      end else if (wr_ext && ext_code == EXT_MICRO_STEP) begin
         clk_state_reg <= CLK_WAIT_FULL;
         fine_run_reg <= 1'b1;
      end else if (wr_ext && ext_code == EXT_IO_STEP) begin
         clk_state_reg <= CLK_WAIT_IO;
         fine_run_reg <= 1'b1;
      end else begin
         case (clk_state_reg)
            CLK_FREE: clk_state_reg <= CLK_FREE;
            CLK_WAIT_FULL: begin
               if (FULL_CLK) begin
                  clk_state_reg <= CLK_WAIT_HALF;
               end
            end
            CLK_WAIT_HALF: begin
               if (HALF_CLK) begin
                  clk_state_reg <= CLK_HALTED;
                  fine_run_reg <= 1'b0;
               end
            end
            CLK_WAIT_IO: begin
               if (IO_ADDR_CHG) begin
                  clk_state_reg <= CLK_HALTED;
                  fine_run_reg <= 1'b0;
               end
            end
            CLK_HALTED: clk_state_reg <= CLK_HALTED;
            default: clk_state_reg <= CLK_FREE;
         endcase
      end
   end

   // ==========================================================
   // Mode and setup
   // ==========================================================
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         ctrl_mode_reg <= 1'b0;
      end else if (wr_ext && ext_code == EXT_CTRL_MODE) begin
         ctrl_mode_reg <= 1'b1;
      end else if (wr_ext && (ext_code == EXT_SETUP_MODE
                   || ext_code == EXT_INIT)) begin
         ctrl_mode_reg <= 1'b0;
      end
   end

   // setup word capture; page is module select
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         su_op_reg <= SU_CENTRAL;
         page_reg <= 4'h0;
      end else if (wr_76 && !ctrl_mode_reg) begin
         su_op_reg <= word_op;
         page_reg <= word[PAGE_HI:PAGE_LO];
      end
   end

   // Microstore address and central word lane
   // address loaded by store and memory setups
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         ms_addr_reg <= '0;
         lane_reg <= 2'h0;
      end else if (wr_76 && !ctrl_mode_reg && word_op <= SU_MEM_ADDR) begin
         ms_addr_reg <= word[WADDR_HI:0];
         lane_reg <= 2'h0;
      end else if (advance) begin
         if (su_op_reg == SU_CENTRAL && lane_reg != LAST_LANE) begin
            lane_reg <= lane_reg + 2'h1;
         end else begin
            lane_reg <= 2'h0;
            ms_addr_reg <= ms_addr_reg + 1'b1;
         end
      end
   end

   // ==========================================================
   // Commands on device 76
   // ==========================================================
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         branch_stb_reg <= 1'b0;
         branch_addr_reg <= 13'h0000;
      end else begin
         branch_stb_reg <= wr_76 && ctrl_mode_reg && word_op == CMD_BRANCH;
         if (wr_76 && ctrl_mode_reg && word_op == CMD_BRANCH) begin
            branch_addr_reg <= word[BRANCH_HI:0];
         end
      end
   end

   // Decoder store selection
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         dec_en_reg <= 1'b0;
         dec_mod_reg <= 4'h0;
      end else if (wr_ext && ext_code == EXT_INIT) begin
         dec_en_reg <= 1'b0;
      end else if (wr_76 && ctrl_mode_reg && word_op == CMD_DEC_EN) begin
         dec_en_reg <= 1'b1;
         dec_mod_reg <= word[PAGE_HI:PAGE_LO];
      end
   end

   // I/O RAM selection, held until the sequencer is idle
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         io_pend_reg <= 1'b0;
         io_pend_mod_reg <= 4'h0;
         io_en_reg <= 1'b0;
         io_mod_reg <= 4'h0;
      end else if (wr_ext && ext_code == EXT_INIT) begin
         io_pend_reg <= 1'b0;
         io_en_reg <= 1'b0;
      end else if (wr_76 && ctrl_mode_reg && word_op == CMD_IO_EN) begin
         io_pend_reg <= 1'b1;
         io_pend_mod_reg <= word[PAGE_HI:PAGE_LO];
      end else if (io_pend_reg && IO_IDLE) begin
         io_pend_reg <= 1'b0;
         io_en_reg <= 1'b1;
         io_mod_reg <= io_pend_mod_reg;
      end
   end

   // ==========================================================
   // Memory load
   // ==========================================================
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         load_reg <= 1'b0;
      end else if (wr_ext && ext_code == EXT_INIT) begin
         load_reg <= 1'b0;
      end else if (wr_ext && ext_code == EXT_MEM_LOAD) begin
         load_reg <= cnt_reg != 16'h0000;
      end else if (load_ack && cnt_reg == 16'h0001) begin
         load_reg <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         cnt_reg <= 16'h0000;
      end else if (load_ack) begin
         cnt_reg <= cnt_reg - 16'h0001;
      end else if (wr_75 && su_op_reg == SU_XFER_CNT) begin
         cnt_reg <= word;
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         mar_reg <= '0;
      end else if (load_ack) begin
         mar_reg <= mar_reg + 1'b1;
      end else if (wr_75 && su_op_reg == SU_MEM_ADDR) begin
         mar_reg <= word[MEM_AW-1:0];
      end
   end

   // ==========================================================
   // Store port
   // ==========================================================
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         cs_we_reg <= 1'b0;
         cs_wdata_reg <= 16'h0000;
      end else begin
         // store writes from load or device 75
         cs_we_reg <= load_ack | (wr_75 & store_op);
         if (load_ack) begin
            cs_wdata_reg <= MEM_RDATA;
         end else if (wr_75) begin
            cs_wdata_reg <= word;
         end
      end
   end

   // Busy sense
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         busy_reg <= 1'b0;
      end else begin
         busy_reg <= busy_next;
      end
   end

   // Store address output lags the counter by one access
   logic [ADDR_W-1:0] cs_addr_reg;
   logic [1:0] cs_lane_reg;
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         cs_addr_reg <= '0;
         cs_lane_reg <= 2'h0;
      end else if (advance || !(cs_we_reg || rd_pend_reg)) begin
         cs_addr_reg <= ms_addr_reg;
         cs_lane_reg <= lane_reg;
      end
   end

   // Outputs
   assign AVS_READDATA = rdata_reg;
   assign AVS_WAITREQUEST = wait_reg;
   assign FINE_CLK_EN = clk_run;
   assign BRANCH_STB = branch_stb_reg;
   assign BRANCH_ADDR = branch_addr_reg;
   assign DEC_EN = dec_en_reg;
   assign DEC_MOD = dec_mod_reg;
   assign IO_RAM_EN = io_en_reg;
   assign IO_RAM_MOD = io_mod_reg;
   assign MEM_REQ = load_reg;
   assign MEM_ADDR = mar_reg;
   assign CS_WE = cs_we_reg;
   assign CS_RE = rd_pend_reg;
   assign CS_SEL = su_op_reg[1:0];
   assign CS_ADDR = cs_addr_reg;
   assign CS_LANE = cs_lane_reg;
   assign CS_WDATA = cs_wdata_reg;
   // no interrupt lines, busy is the only status
   assign BUSY_SENSE = busy_reg;

endmodule : microstore_io_command_port

/* File: testbench/microstore_io_command_port_checker.sv */
// Pin-level assertions for the microstore command port
`timescale 1ns/1ns
module microstore_io_command_port_checker
   import microstore_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic [4:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic AVS_WAITREQUEST,
   input wire logic HALF_CLK,
   input wire logic IO_ADDR_CHG,
   input wire logic IO_IDLE,
   input wire logic FINE_CLK_EN,
   input wire logic BRANCH_STB,
   input wire logic IO_RAM_EN,
   input wire logic MEM_REQ,
   input wire logic MEM_ACK,
   input wire logic CS_WE,
   input wire logic CS_RE,
   input wire logic BUSY_SENSE
);
   // ==========================================
   // Clocking and reset for all properties
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   a_answer_needs_req: assert property (
      !AVS_WAITREQUEST |-> $past(AVS_READ || AVS_WRITE))
      else $error("answer without request");
   a_answer_once: assert property (
      !AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("waitrequest low too long");
   a_branch_pulse: assert property (
      BRANCH_STB |=> !BRANCH_STB)
      else $error("branch strobe too long");
   a_busy_cause: assert property (
      BUSY_SENSE |-> (MEM_REQ || $past(MEM_REQ)) &&
         (FINE_CLK_EN || $past(FINE_CLK_EN)))
      else $error("busy without cause");
   a_load_writes: assert property (
      MEM_REQ && MEM_ACK |=> CS_WE)
      else $error("load word not written");
   a_load_holds: assert property (
      MEM_REQ && !MEM_ACK &&
         !(AVS_WRITE && AVS_ADDRESS == OFS_EXT_CMD) |=> MEM_REQ)
      else $error("load ended without a word");
   // halt only at a step point
   a_halt_cause: assert property (
      $fell(FINE_CLK_EN) |-> HALF_CLK || IO_ADDR_CHG ||
         $past(HALF_CLK || IO_ADDR_CHG))
      else $error("halt without step event");
   a_io_en_idle: assert property (
      $rose(IO_RAM_EN) |-> IO_IDLE || $past(IO_IDLE))
      else $error("io ram enabled while busy");
   // one store access at a time
   a_we_re_excl: assert property (
      !(CS_WE && CS_RE))
      else $error("store write and read together");
endmodule : microstore_io_command_port_checker

bind microstore_io_command_port microstore_io_command_port_checker chk_inst (
   .*
);

/* File: testbench/microstore_far_model.sv */
// Main memory and control store model beside the command port
`timescale 1ns/1ns
module microstore_far_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic slow,
   input wire logic mem_req,
   input wire logic [15:0] mem_addr,
   output logic mem_ack,
   output logic [15:0] mem_rdata,
   input wire logic cs_we,
   input wire logic cs_re,
   input wire logic [1:0] cs_sel,
   input wire logic [8:0] cs_addr,
   input wire logic [1:0] cs_lane,
   input wire logic [15:0] cs_wdata,
   output logic [15:0] cs_rdata
);
   logic [15:0] store [0:8191];
   logic [15:0] load_q [$];
   logic [2:0] dly_reg;
   // ==========================================
   // Memory side
   // words fetched on request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mem_ack <= 1'b0;
         dly_reg <= 3'h0;
      end else if (mem_req && !mem_ack && (!slow || dly_reg == 3'h7)) begin
         mem_ack <= 1'b1;
         dly_reg <= 3'h0;
      end else begin
         mem_ack <= 1'b0;
         dly_reg <= dly_reg + 3'h1;
      end
   end
   // Data line inverted outside the answer cycle
   assign mem_rdata = mem_ack ? mem_addr ^ 16'h5A5A : ~(mem_addr ^ 16'h5A5A);
   // ==========================================
   // Store side
   // store keeps written words
   always_ff @(posedge clk) begin
      if (cs_we) begin
         store[{cs_sel, cs_addr, cs_lane}] <= cs_wdata;
         load_q.push_back(cs_wdata);
      end
   end
   // Read data only while strobed
   assign cs_rdata = cs_re ? store[{cs_sel, cs_addr, cs_lane}] : ~cs_wdata;
endmodule : microstore_far_model

/* File: testbench/microstore_io_command_port_tb.sv */
// Self-checking bench for the microstore command port
`timescale 1ns/1ns
module microstore_io_command_port_tb
   import microstore_pkg::*;
;
   logic clk_sys, rst, avs_read, avs_write, avs_waitrequest, full_clk;
   logic half_clk, io_addr_chg, io_idle, slow, fine_clk_en, branch_stb;
   logic dec_en, io_ram_en, mem_req, mem_ack, cs_we, cs_re, busy_sense;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0] proc_module, dec_mod, io_ram_mod, pg;
   logic [12:0] cur_cs_addr, branch_addr, b;
   logic [15:0] pseudo_ir, io_addr, mem_addr, mem_rdata, cs_wdata, cs_rdata;
   logic [15:0] ma, dat [0:3];
   logic [1:0] cs_sel, cs_lane;
   logic [8:0] cs_addr, a;
   int err_total, checks, br_cnt, n, seed;

   microstore_io_command_port microstore_io_command_port_inst (
      .CLK_SYS(clk_sys), .RST(rst), .AVS_ADDRESS(avs_address),
      .AVS_READ(avs_read), .AVS_WRITE(avs_write),
      .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hF),
      .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
      .FULL_CLK(full_clk), .HALF_CLK(half_clk), .IO_ADDR_CHG(io_addr_chg),
      .IO_IDLE(io_idle), .PROC_MODULE(proc_module),
      .CUR_CS_ADDR(cur_cs_addr), .PSEUDO_IR(pseudo_ir), .IO_ADDR(io_addr),
      .FINE_CLK_EN(fine_clk_en), .BRANCH_STB(branch_stb),
      .BRANCH_ADDR(branch_addr), .DEC_EN(dec_en), .DEC_MOD(dec_mod),
      .IO_RAM_EN(io_ram_en), .IO_RAM_MOD(io_ram_mod), .MEM_REQ(mem_req),
      .MEM_ADDR(mem_addr), .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata),
      .CS_WE(cs_we), .CS_RE(cs_re), .CS_SEL(cs_sel), .CS_ADDR(cs_addr),
      .CS_LANE(cs_lane), .CS_WDATA(cs_wdata), .CS_RDATA(cs_rdata),
      .BUSY_SENSE(busy_sense));

   microstore_far_model far_inst (
      .clk(clk_sys), .rst(rst), .slow(slow), .mem_req(mem_req),
      .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .cs_we(cs_we), .cs_re(cs_re), .cs_sel(cs_sel), .cs_addr(cs_addr),
      .cs_lane(cs_lane), .cs_wdata(cs_wdata), .cs_rdata(cs_rdata));

   // ==========================================
   // Helpers
   function automatic logic [15:0] su(input logic [2:0] op,
      input logic [3:0] p, input logic [8:0] ad);
      return {op, p, ad};
   endfunction : su

   // Compare and count
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // One Avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] ad,
      input logic [15:0] d);
      int k = 0;
      avs_address <= ad;
      avs_writedata <= {16'h0, d};
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0 && k < 200) begin
         k++;
         @(posedge clk_sys);
      end
      if (k == 200) err_total++;
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_sys);
   endtask : bus

   // External command write
   task automatic ext(input logic [8:0] c);
      bus(1'b1, OFS_EXT_CMD, {7'h0, c});
   endtask : ext

   // One-cycle processor event then settle
   task automatic pulse(input int k);
      {io_addr_chg, half_clk, full_clk} <= 3'(1 << k);
      @(posedge clk_sys);
      {full_clk, half_clk, io_addr_chg} <= 3'h0;
      repeat (2) @(posedge clk_sys);
   endtask : pulse

   task automatic end_of_test();
      if (err_total == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_of_test

   // ==========================================
   // Clock, strobe counter and watchdog
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) if (branch_stb === 1'b1) br_cnt++;
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      end_of_test();
   end

   // ==========================================
   // Main sequence
   initial begin
      {rst, io_idle} = 2'h3;
      {avs_read, avs_write, full_clk, half_clk, io_addr_chg, slow} = 6'h0;
      {avs_address, avs_writedata, proc_module} = 41'h0;
      {cur_cs_addr, pseudo_ir, io_addr} = 45'h0;
      {err_total, checks, br_cnt} = 3'h0;
      seed = $urandom(9);
      pg = 4'($urandom);
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      bus(1'b0, OFS_STATUS, 16'h0);
      chk("ctrl_mode", 32'h0, 32'(rd[ST_CTRL]));
      bus(1'b0, 5'h1C, 16'h0);
      chk("unmapped", 32'h0, rd);
      ext(EXT_MICRO_STEP);
      pulse(1);
      chk("fine_clk", 32'h1, 32'(fine_clk_en));
      pulse(0);
      pulse(1);
      chk("fine_clk", 32'h0, 32'(fine_clk_en));
      ext(EXT_RUN_FREE);
      chk("fine_clk", 32'h1, 32'(fine_clk_en));
      ext(EXT_IO_STEP);
      pulse(0);
      pulse(1);
      chk("fine_clk", 32'h1, 32'(fine_clk_en));
      pulse(2);
      chk("fine_clk", 32'h0, 32'(fine_clk_en));
      ext(EXT_INIT);
      chk("fine_clk", 32'h1, 32'(fine_clk_en));
      // store round trips, all four stores
      for (int op = 0; op < 4; op++) begin
         a = 9'($urandom);
         bus(1'b1, OFS_OUT76, su(3'(op), pg, a));
         for (int i = 0; i < (op == 0 ? 4 : 2); i++) begin
            dat[i] = 16'($urandom);
            bus(1'b1, OFS_DATA75, dat[i]);
         end
         bus(1'b0, OFS_MS_ADDR, 16'h0);
         chk("ms_addr", 32'(a + (op == 0 ? 9'h1 : 9'h2)), rd);
         bus(1'b1, OFS_OUT76, su(3'(op), pg, a));
         for (int i = 0; i < (op == 0 ? 4 : 2); i++) begin
            bus(1'b0, OFS_DATA75, 16'h0);
            chk("store_word", 32'(dat[i]), 32'(rd[15:0]));
         end
      end
      bus(1'b0, OFS_STATUS, 16'h0);
      chk("setup_fields", 32'({3'h3, pg}), 32'(rd[15:9]));
      // input selections, unassigned one reads zero
      {cur_cs_addr, pseudo_ir, io_addr} <= 45'({$urandom, $urandom});
      foreach (dat[i]) begin
         bus(1'b1, OFS_OUT76, su(3'(i + 4), pg, 9'h0));
         bus(1'b0, OFS_DATA75, 16'h0);
         case (i)
            0: chk("in_cs_addr", 32'(cur_cs_addr), 32'(rd[15:0]));
            1: chk("in_pir", 32'(pseudo_ir), 32'(rd[15:0]));
            2: chk("in_unused", 32'h0, 32'(rd[15:0]));
            default: chk("in_io_addr", 32'(io_addr), 32'(rd[15:0]));
         endcase
      end
      // slow memory load, then a load aborted
      for (int t = 0; t < 2; t++) begin
         ma = 16'($urandom);
         bus(1'b1, OFS_OUT76, su(3'h4, pg, 9'h0));
         bus(1'b1, OFS_DATA75, ma);
         bus(1'b1, OFS_OUT76, su(3'h5, pg, 9'h0));
         bus(1'b1, OFS_DATA75, 16'h3);
         bus(1'b1, OFS_OUT76, su(3'h0, pg, 9'h10));
         proc_module <= pg;
         slow <= 1'b1;
         far_inst.load_q.delete();
         ext(EXT_MEM_LOAD);
         repeat (2) @(posedge clk_sys);
         chk("busy", 32'h1, 32'(busy_sense));
         if (t == 1) ext(EXT_INIT);
         n = 0;
         while (mem_req && n < 300) begin
            n++;
            @(posedge clk_sys);
         end
         repeat (2) @(posedge clk_sys);
         bus(1'b0, OFS_STATUS, 16'h0);
         chk("load_flag", 32'h0, 32'(rd[ST_LOAD]));
         if (t == 0) begin
            chk("words", 32'h3, 32'(far_inst.load_q.size()));
            for (int i = 0; i < 3; i++)
               chk("load_word", 32'((ma + 16'(i)) ^ 16'h5A5A),
                  32'(far_inst.load_q[i]));
         end
      end
      ext(EXT_CTRL_MODE);
      b = 13'($urandom);
      n = br_cnt;
      bus(1'b1, OFS_OUT76, {3'h0, b});
      @(posedge clk_sys);
      chk("branch", 32'({n + 1, b}), 32'({br_cnt, branch_addr}));
      bus(1'b1, OFS_OUT76, su(3'h1, pg, 9'h0));
      chk("dec_sel", 32'({1'b1, pg}), 32'({dec_en, dec_mod}));
      io_idle <= 1'b0;
      bus(1'b1, OFS_OUT76, su(3'h3, ~pg, 9'h0));
      repeat (3) @(posedge clk_sys);
      chk("io_en_held", 32'h0, 32'(io_ram_en));
      // sequencer idles on its ROM-identical last word
      io_idle <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk("io_sel", 32'({1'b1, ~pg}), 32'({io_ram_en, io_ram_mod}));
      ext(EXT_SETUP_MODE);
      n = br_cnt;
      bus(1'b1, OFS_OUT76, {3'h0, b});
      repeat (2) @(posedge clk_sys);
      chk("no_branch", 32'(n), 32'(br_cnt));
      ext(EXT_CTRL_MODE);
      ext(EXT_INIT);
      bus(1'b0, OFS_STATUS, 16'h0);
      chk("init_clear", 32'h0, 32'({rd[ST_CTRL], dec_en, io_ram_en}));
      end_of_test();
   end
endmodule : microstore_io_command_port_tb
